// >>> logic/sram_byte_write_mask.v
`timescale 1ns/1ps
`include "sram_mask_defines.vh"

// Contract
// - First beat follows the address cycle, second beat the next edge.
// - Lane selects only act on beats of a properly started write.
// - Selects are sampled per beat and may differ between beats.
// - x8/x18: both selects low write the whole beat.
// - x8: select0 low, select1 high writes bits 3..0 only.
// - x8: select0 high, select1 low writes bits 7..4 only.
// - x18: select0 low, select1 high writes bits 8..0 only.
// - x18: select0 high, select1 low writes bits 17..9 only.
// - x8/x18: both selects high write nothing for that beat.
// - x9: single select low writes bits 8..0.
// - x9: single select high suppresses the beat's write.
// - x36: all four selects low write bits 35..0.
// - x36: each select gates its own nine-bit lane.
// - x36: all four selects high write nothing.
module sram_byte_write_mask
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire awvalid,
    output wire awready,
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // AXI4-Lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // AXI4-Lite read
    input wire arvalid,
    output wire arready,
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // Memory write pins
    input wire load_strobe_n,
    input wire read_write_n,
    input wire [3:0] wr_addr,
    input wire [35:0] wr_data,
    input wire [3:0] byte_lane_write_select_n,
    input wire [1:0] nibble_lane_write_select_n,
    output wire beat_ready
);

    // -----------------------------------------------------------
    // Write cycle sequencer
    // -----------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_BEAT0 = 3'b010;
    localparam ST_BEAT1 = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [3:0] burst_addr;
    reg [1:0] org;
    reg hold;
    reg [4:0] peek_addr;
    reg [7:0] beat_cnt;
    reg [7:0] drop_cnt;
    reg push_valid;
    reg [`ENTRY_W-1:0] push_data;
    wire start;
    wire in_beat;
    wire [3:0] beat_sel_n;

    assign start = !load_strobe_n && !read_write_n;

    always @*
    begin
        case (state)
            ST_IDLE: next_state = start ? ST_BEAT0 : ST_IDLE;
            ST_BEAT0: next_state = ST_BEAT1;
            ST_BEAT1: next_state = start ? ST_BEAT0 : ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Address taken only when a new write may start
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            burst_addr <= 4'h0;
        end
        else
        begin
            state <= next_state;
            if (start && (state == ST_IDLE || state == ST_BEAT1))
                burst_addr <= wr_addr;
        end
    end

    // -----------------------------------------------------------
    // Beat capture
    // -----------------------------------------------------------
    // Outside the beats the selects are never sampled
    assign in_beat = (state == ST_BEAT0) || (state == ST_BEAT1);

    // x8 takes its two lanes from the nibble selects
    assign beat_sel_n = (org == `ORG_X8) ?
        {2'b11, nibble_lane_write_select_n} : byte_lane_write_select_n;

    // Entry: org, address, beat, data, selects
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            push_valid <= 1'b0;
            push_data <= {`ENTRY_W{1'b0}};
        end
        else
        begin
            push_valid <= in_beat;
            if (in_beat)
                push_data <= {org, burst_addr, state == ST_BEAT1,
                              wr_data, beat_sel_n};
        end
    end

    // -----------------------------------------------------------
    // Beat buffer and array
    // -----------------------------------------------------------
    wire buf_ready;
    wire out_valid;
    wire out_ready;
    wire [`ENTRY_W-1:0] out_data;
    wire [1:0] org_o;
    wire [4:0] idx_o;
    wire [35:0] data_o;
    wire [3:0] sel_o;
    wire [35:0] bit_en;
    wire drain;
    reg [35:0] mem [0:31];

    beat_buffer #(
        .W(`ENTRY_W)
    )
    u_buf
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(push_valid),
        .in_ready(buf_ready),
        .in_data(push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    assign beat_ready = buf_ready;
    // Hold stalls the drain so the buffer can really fill
    assign out_ready = !hold;
    assign drain = out_valid && out_ready;
    assign org_o = out_data[46:45];
    assign idx_o = out_data[44:40];
    assign data_o = out_data[39:4];
    assign sel_o = out_data[3:0];

    genvar i;
    generate
        for (i = 0; i < 36; i = i + 1)
        begin : g_bit
            localparam integer L8 = (i < 4) ? 0 : 1;
            localparam integer L36 = i / 9;
            localparam integer L18 = (i < 18) ? i / 9 : 0;
            localparam [0:0] IN8 = (i < 8);
            localparam [0:0] IN9 = (i < 9);
            localparam [0:0] IN18 = (i < 18);
            assign bit_en[i] =
                (org_o == `ORG_X8) ? IN8 && !sel_o[L8] :
                (org_o == `ORG_X9) ? IN9 && !sel_o[0] :
                (org_o == `ORG_X18) ? IN18 && !sel_o[L18] :
                !sel_o[L36];
        end
    endgenerate

    // Unselected bits keep their stored value
    always @(posedge aclk)
    begin
        if (drain)
            mem[idx_o] <= (mem[idx_o] & ~bit_en)
                | (data_o & bit_en);
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            beat_cnt <= 8'h00;
            drop_cnt <= 8'h00;
        end
        else
        begin
            if (drain)
                beat_cnt <= beat_cnt + 8'h01;
            if (push_valid && !buf_ready)
                drop_cnt <= drop_cnt + 8'h01;
        end
    end

    // -----------------------------------------------------------
    // AXI4-Lite slave
    // -----------------------------------------------------------
    reg aw_held;
    reg w_held;
    reg [7:0] aw_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;
    reg [31:0] rd_mux;
    reg rd_ok;
    reg wr_ok;
    wire do_write;
    wire [7:0] aw_word;
    wire [7:0] ar_word;
    wire [35:0] peek_word;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_held && w_held;
    assign aw_word = {aw_q[7:2], 2'b00};
    assign ar_word = {araddr[7:2], 2'b00};
    assign peek_word = mem[peek_addr];

    always @*
    begin
        wr_ok = (aw_word == `REG_CTRL) || (aw_word == `REG_STATUS)
            || (aw_word == `REG_PEEK_ADDR) || (aw_word == `REG_PEEK_LO)
            || (aw_word == `REG_PEEK_HI);
    end

    always @*
    begin
        rd_ok = 1'b1;
        rd_mux = 32'h00000000;
        case (ar_word)
            `REG_CTRL:
                rd_mux = {29'h0, hold, org};
            `REG_STATUS:
                rd_mux = {12'h000, state, out_valid, drop_cnt, beat_cnt};
            `REG_PEEK_ADDR:
                rd_mux = {27'h0, peek_addr};
            `REG_PEEK_LO:
                rd_mux = peek_word[31:0];
            `REG_PEEK_HI:
                rd_mux = {28'h0, peek_word[35:32]};
            default:
                rd_ok = 1'b0;
        endcase
    end

    // Address and data may arrive in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            org <= `CTRL_ORG_RESET;
            hold <= `CTRL_HOLD_RESET;
            peek_addr <= `PEEK_ADDR_RESET;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                wd_q <= wdata;
                ws_q <= wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (aw_word == `REG_CTRL && ws_q[0])
                begin
                    org <= wd_q[`CTRL_ORG_MSB:`CTRL_ORG_LSB];
                    hold <= wd_q[`CTRL_HOLD_BIT];
                end
                if (aw_word == `REG_PEEK_ADDR && ws_q[0])
                    peek_addr <= wd_q[4:0];
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

endmodule // sram_byte_write_mask

// >>> logic/sram_mask_defines.vh
`ifndef SRAM_MASK_DEFINES_VH
`define SRAM_MASK_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PEEK_ADDR 8'h08
`define REG_PEEK_LO 8'h0C
`define REG_PEEK_HI 8'h10

// ---------------------------------------------------------------
// Control fields and reset values
// ---------------------------------------------------------------
`define CTRL_ORG_LSB 0
`define CTRL_ORG_MSB 1
`define CTRL_HOLD_BIT 2
`define CTRL_ORG_RESET 2'h3
`define CTRL_HOLD_RESET 1'h0
`define PEEK_ADDR_RESET 5'h00

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define STAT_BEATS_LSB 0
`define STAT_DROPS_LSB 8
`define STAT_PENDING_BIT 16
`define STAT_STATE_LSB 17

// ---------------------------------------------------------------
// Organisations
// ---------------------------------------------------------------
`define ORG_X8 2'h0
`define ORG_X9 2'h1
`define ORG_X18 2'h2
`define ORG_X36 2'h3

// ---------------------------------------------------------------
// Bus responses and sizes
// ---------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_W 36
`define ADDR_W 4
`define ENTRY_W 47

`endif

// >>> logic/beat_buffer.v
`timescale 1ns/1ps

// Two-entry buffer; a stalled drain side loses no word
module beat_buffer #(
    parameter W = 47
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

    reg [W-1:0] slot0;
    reg [W-1:0] slot1;
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = rd_ptr ? slot1 : slot0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end

    // Slots need no reset; count guards their use
    always @(posedge aclk)
    begin
        if (push && !wr_ptr)
            slot0 <= in_data;
        if (push && wr_ptr)
            slot1 <= in_data;
    end

endmodule // beat_buffer

// >>> verification/sram_mask_checker.sv
`timescale 1ns/1ps
module sram_mask_checker (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire bvalid,
    input wire bready,
    input wire [1:0] bresp,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire [31:0] rdata
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_b_end: assert property (bvalid && bready |=> !bvalid)
        else $error("write response not retired");
    a_b_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_b_time: assert property (awvalid && awready && wvalid && wready
        |-> ##[1:2] bvalid) else $error("write response late");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_r_end: assert property (rvalid && rready |=> !rvalid)
        else $error("read data not retired");
    a_r_gate: assert property (arready == !rvalid)
        else $error("read address ready wrong");
    a_r_time: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
endmodule // sram_mask_checker

bind sram_byte_write_mask sram_mask_checker chk (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
    .rvalid, .rready, .rdata);

// >>> verification/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model (
    // Clock
    input wire aclk,
    // Memory write pins
    output logic load_strobe_n = 1'h1,
    output logic read_write_n = 1'h1,
    output logic [3:0] wr_addr = 4'h0,
    output logic [35:0] wr_data = 36'h0,
    output logic [3:0] byte_lane_write_select_n = 4'h0,
    output logic [1:0] nibble_lane_write_select_n = 2'h0
);
    // Outside beats the selects stay active and data flips
    task burst(input [3:0] a, input rw, input [35:0] d0, input [3:0] b0,
        input [1:0] n0, input [35:0] d1, input [3:0] b1, input [1:0] n1);
        @(posedge aclk);
        load_strobe_n <= 1'h0;
        read_write_n <= rw;
        wr_addr <= a;
        @(posedge aclk);
        load_strobe_n <= 1'h1;
        wr_data <= d0;
        byte_lane_write_select_n <= b0;
        nibble_lane_write_select_n <= n0;
        @(posedge aclk);
        wr_data <= d1;
        byte_lane_write_select_n <= b1;
        nibble_lane_write_select_n <= n1;
        @(posedge aclk);
        wr_data <= ~d1;
        wr_addr <= ~a;
        byte_lane_write_select_n <= 4'h0;
        nibble_lane_write_select_n <= 2'h0;
    endtask
endmodule // mem_ctrl_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "sram_mask_defines.vh"
module tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, beat_ready;
    logic load_strobe_n, read_write_n;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rsp, nibble_lane_write_select_n;
    logic [3:0] wr_addr, byte_lane_write_select_n;
    logic [35:0] wr_data;
    logic [35:0] sh [0:31];
    integer failures = 0, tests_run = 0, cyc = 0;

    sram_byte_write_mask dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
        .rready, .rdata, .rresp, .load_strobe_n, .read_write_n, .wr_addr,
        .wr_data, .byte_lane_write_select_n, .nibble_lane_write_select_n,
        .beat_ready);
    mem_ctrl_model ctrl (.aclk, .load_strobe_n, .read_write_n, .wr_addr,
        .wr_data, .byte_lane_write_select_n, .nibble_lane_write_select_n);

    initial
    begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end

    task cmp(input string nm, input [35:0] e, input [35:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Ready stands from the request on; the answer is taken at its edge.
    // The leading edge keeps back-to-back calls off one time step.
    task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask

    task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    function [35:0] msk(input [1:0] o, input [3:0] b, input [1:0] n);
        case (o)
            2'h0: msk = {28'h0, {4{~n[1]}}, {4{~n[0]}}};
            2'h1: msk = {27'h0, {9{~b[0]}}};
            2'h2: msk = {18'h0, {9{~b[1]}}, {9{~b[0]}}};
            default: msk = {{9{~b[3]}}, {9{~b[2]}}, {9{~b[1]}}, {9{~b[0]}}};
        endcase
    endfunction

    task peek(input [4:0] i);
        logic [31:0] lo, hi;
        axi_wr(`REG_PEEK_ADDR, {27'h0, i}, rsp);
        axi_rd(`REG_PEEK_LO, lo, rsp);
        axi_rd(`REG_PEEK_HI, hi, rsp);
        cmp("peek resp", {34'h0, `RESP_OKAY}, {34'h0, rsp});
        cmp("array word", sh[i], {hi[3:0], lo});
    endtask

    task run(input [1:0] o, input [3:0] a, input [35:0] d0, input [3:0] b0,
        input [1:0] n0, input [35:0] d1, input [3:0] b1, input [1:0] n1);
        logic [35:0] m0, m1;
        m0 = msk(o, b0, n0);
        m1 = msk(o, b1, n1);
        ctrl.burst(a, 1'h0, d0, b0, n0, d1, b1, n1);
        sh[{a, 1'h0}] = sh[{a, 1'h0}] & ~m0 | d0 & m0;
        sh[{a, 1'h1}] = sh[{a, 1'h1}] & ~m1 | d1 & m1;
        repeat (3) @(posedge aclk);
        peek({a, 1'h0});
        peek({a, 1'h1});
    endtask

    task t_regs;
        axi_rd(`REG_CTRL, rd, rsp);
        cmp("ctrl", 36'h3, {4'h0, rd});
        cmp("ctrl rd resp", {34'h0, `RESP_OKAY}, {34'h0, rsp});
        axi_rd(8'hFC, rd, rsp);
        cmp("unmapped rd resp", {34'h0, `RESP_SLVERR}, {34'h0, rsp});
        axi_rd(`REG_STATUS, rd, rsp);
        cmp("status", 36'h2_0000, {4'h0, rd});
        axi_wr(8'hFC, 32'h0, rsp);
        cmp("unmapped resp", {34'h0, `RESP_SLVERR}, {34'h0, rsp});
    endtask

    task t_x36;
        integer k;
        run(2'h3, 4'h1, 36'hF_0123_4567, 4'h0, 2'h3, 36'h0_89AB_CDEF, 4'h0,
            2'h3);
        for (k = 0; k < 4; k++)
            run(2'h3, 4'h1, 36'hA_5A5A_5A5A ^ k, ~(4'h1 << k), 2'h0,
                36'h3_C3C3_C3C3, ~(4'h8 >> k), 2'h0);
        run(2'h3, 4'h1, 36'h0, 4'hF, 2'h0, 36'h0, 4'hF, 2'h0);
    endtask

    task t_org(input [1:0] o);
        integer k;
        axi_wr(`REG_CTRL, {30'h0, o}, rsp);
        cmp("ctrl wr resp", {34'h0, `RESP_OKAY}, {34'h0, rsp});
        for (k = 0; k < 4; k++)
            run(o, 4'h1, 36'h9_6C3A_5F21 + k, {2'h0, k[1:0]}, k[1:0],
                36'h6_93C5_A0DE - k, {2'h0, ~k[1:0]}, ~k[1:0]);
    endtask

    task t_outside;
        ctrl.burst(4'h1, 1'h1, 36'h0, 4'h0, 2'h0, 36'h0, 4'h0, 2'h0);
        repeat (3) @(posedge aclk);
        peek(5'h02);
        peek(5'h03);
    endtask

    task t_hold;
        integer k;
        axi_wr(`REG_CTRL, 32'h7, rsp);
        ctrl.burst(4'h2, 1'h0, 36'hE_1234_5678, 4'h0, 2'h0, 36'h1_FEDC_BA98,
            4'h0, 2'h0);
        ctrl.burst(4'h3, 1'h0, 36'h0, 4'h0, 2'h0, 36'h0, 4'h0, 2'h0);
        repeat (2) @(posedge aclk);
        cmp("beat_ready", 36'h0, {35'h0, beat_ready});
        axi_rd(`REG_STATUS, rd, rsp);
        cmp("drops", 36'h2, {28'h0, rd[15:8]});
        // 18 drained bursts of two beats, idle, buffer still holding
        cmp("status held", 36'h3_0224, {4'h0, rd});
        sh[4] = 36'hE_1234_5678;
        sh[5] = 36'h1_FEDC_BA98;
        axi_wr(`REG_CTRL, 32'h3, rsp);
        repeat (3) @(posedge aclk);
        for (k = 4; k < 8; k++)
            peek(k[4:0]);
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            end_of_test;
        end
    end

    initial
    begin
        aresetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs;
        t_x36;
        t_org(2'h2);
        t_org(2'h0);
        t_org(2'h1);
        t_outside;
        t_hold;
        end_of_test;
    end
endmodule // tb_top
